// ### hw/pic_controller.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "pic_regs.svh"
module pic_controller (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire pic_pkg::pic_apb_req_t apb_i,
  output pic_pkg::pic_apb_rsp_t apb_o,
  input wire logic [`PIC_SLOTS-1:0] event_i,
  input wire logic [2:0] ext_int_i,
  input wire logic [2:0] gpio_port_i,
  input wire logic global_interrupt_enable_i,
  input wire logic instr_done_i,
  input wire pic_pkg::pic_cpu_ctx_t ctx_i,
  output pic_pkg::pic_dispatch_t disp_o,
  output logic irq_request_o
);
  pic_pkg::pic_core_t core_reg;
  pic_pkg::pic_core_t core_next;

  logic [`PIC_PIN_COUNT-1:0] pin_rise;
  logic [`PIC_SLOTS-1:0] pin_slots;
  logic [`PIC_SLOTS-1:0] hw_set;
  logic [`PIC_SLOTS-1:0] pending;

  // Place register bytes onto slot positions
  function automatic logic [`PIC_SLOTS-1:0] slots_of(
    input logic [7:0] b0,
    input logic [7:0] b1,
    input logic [7:0] b2
  );
    logic [`PIC_SLOTS-1:0] s;
    s = '0;
    s[`PIC_SLOT_POWER_ON] = b0[`PIC_C0_POWER_ON];
    s[`PIC_SLOT_EXT0] = b0[`PIC_C0_EXT0];
    s[`PIC_SLOT_SPI_TX] = b0[`PIC_C0_SPI_TX];
    s[`PIC_SLOT_SPI_RX] = b0[`PIC_C0_SPI_RX];
    s[`PIC_SLOT_GPIO0] = b0[`PIC_C0_GPIO0];
    s[`PIC_SLOT_EXT1] = b0[`PIC_C0_EXT1];
    s[`PIC_SLOT_SLEEP] = b0[`PIC_C0_SLEEP];
    s[`PIC_SLOT_GPIO1] = b0[`PIC_C0_GPIO1];
    for (int i = 0; i < `PIC_C1_FIELDS; i++) begin
      s[`PIC_SLOT_USB_FIRST + i] = b1[i];
    end
    s[`PIC_SLOT_WRAP] = b2[`PIC_C2_WRAP];
    s[`PIC_SLOT_EXT2] = b2[`PIC_C2_EXT2];
    s[`PIC_SLOT_GPIO2] = b2[`PIC_C2_GPIO2];
    // Reserved and reset slots dropped
    return s & `PIC_VALID_SLOTS;
  endfunction

  // Gather slot flags back into one clear register view
  function automatic logic [7:0] byte_of(
    input logic [`PIC_SLOTS-1:0] s,
    input logic [1:0] k
  );
    logic [7:0] b;
    b = `PIC_RESET_BYTE;
    if (k == 2'd0) begin
      b[`PIC_C0_POWER_ON] = s[`PIC_SLOT_POWER_ON];
      b[`PIC_C0_EXT0] = s[`PIC_SLOT_EXT0];
      b[`PIC_C0_SPI_TX] = s[`PIC_SLOT_SPI_TX];
      b[`PIC_C0_SPI_RX] = s[`PIC_SLOT_SPI_RX];
      b[`PIC_C0_GPIO0] = s[`PIC_SLOT_GPIO0];
      b[`PIC_C0_EXT1] = s[`PIC_SLOT_EXT1];
      b[`PIC_C0_SLEEP] = s[`PIC_SLOT_SLEEP];
      b[`PIC_C0_GPIO1] = s[`PIC_SLOT_GPIO1];
    end else if (k == 2'd1) begin
      for (int i = 0; i < `PIC_C1_FIELDS; i++) begin
        b[i] = s[`PIC_SLOT_USB_FIRST + i];
      end
    end else if (k == 2'd2) begin
      b[`PIC_C2_WRAP] = s[`PIC_SLOT_WRAP];
      b[`PIC_C2_EXT2] = s[`PIC_SLOT_EXT2];
      b[`PIC_C2_GPIO2] = s[`PIC_SLOT_GPIO2];
    end
    return b;
  endfunction

  // Byte address of a register index
  function automatic logic [`PIC_ADDR_W-1:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Lowest numbered pending slot
  function automatic logic [`PIC_SLOT_W-1:0] first_slot(input logic [`PIC_SLOTS-1:0] p);
    logic [`PIC_SLOT_W-1:0] f;
    f = '0;
    for (int i = `PIC_SLOTS - 1; i >= 0; i--) begin
      if (p[i]) begin
        f = i[`PIC_SLOT_W-1:0];
      end
    end
    return f;
  endfunction

  // Vector address low byte is slot times four
  function automatic logic [7:0] vector_of(input logic [`PIC_SLOT_W-1:0] slot);
    return {1'b0, slot, 2'b00};
  endfunction

  pic_edge_sync u_edge_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .level_i({gpio_port_i, ext_int_i}),
    .rise_o(pin_rise)
  );

  always_comb begin
    pin_slots = '0;
    pin_slots[`PIC_SLOT_EXT0] = pin_rise[`PIC_PIN_EXT0];
    pin_slots[`PIC_SLOT_EXT1] = pin_rise[`PIC_PIN_EXT1];
    pin_slots[`PIC_SLOT_EXT2] = pin_rise[`PIC_PIN_EXT2];
    pin_slots[`PIC_SLOT_GPIO0] = pin_rise[`PIC_PIN_GPIO0];
    pin_slots[`PIC_SLOT_GPIO1] = pin_rise[`PIC_PIN_GPIO1];
    pin_slots[`PIC_SLOT_GPIO2] = pin_rise[`PIC_PIN_GPIO2];
  end

  // Events post regardless of mask state
  assign hw_set = (event_i | pin_slots) & `PIC_VALID_SLOTS;

  // Mask only gates posted into pending
  assign pending = core_reg.posted
    & slots_of(core_reg.mask0, core_reg.mask1, core_reg.mask2);

  always_comb begin
    logic setup;
    logic wen;
    logic [7:0] wd;
    logic [`PIC_ADDR_W-1:0] adr;
    logic [`PIC_SLOTS-1:0] own;
    logic [`PIC_SLOTS-1:0] data;
    logic [`PIC_SLOTS-1:0] sw_clear;
    logic [`PIC_SLOTS-1:0] sw_set;
    logic [`PIC_SLOTS-1:0] take_clear;
    logic [`PIC_SLOT_W-1:0] pick;
    setup = 1'b0;
    wen = 1'b0;
    wd = apb_i.pwdata[7:0];
    adr = apb_i.paddr;
    own = '0;
    data = '0;
    sw_clear = '0;
    sw_set = '0;
    take_clear = '0;
    pick = '0;
    core_next = core_reg;
    core_next.disp.push = 1'b0;
    core_next.disp.flags_clear = 1'b0;
    core_next.disp.pc_load = 1'b0;

    // Read data and error prepared in the setup cycle
    setup = apb_i.psel & ~apb_i.penable;
    if (setup) begin
      core_next.pslverr = 1'b0;
      core_next.prdata = 32'h0000_0000;
      if (adr == addr_of(`PIC_IDX_CLEAR0)) begin
        core_next.prdata = {24'h00_0000, byte_of(core_reg.posted, 2'd0)};
      end else if (adr == addr_of(`PIC_IDX_CLEAR1)) begin
        core_next.prdata = {24'h00_0000, byte_of(core_reg.posted, 2'd1)};
      end else if (adr == addr_of(`PIC_IDX_CLEAR2)) begin
        core_next.prdata = {24'h00_0000, byte_of(core_reg.posted, 2'd2)};
      end else if (adr == addr_of(`PIC_IDX_MASK0)) begin
        core_next.prdata = {24'h00_0000, core_reg.mask0};
      end else if (adr == addr_of(`PIC_IDX_MASK1)) begin
        core_next.prdata = {24'h00_0000, core_reg.mask1};
      end else if (adr == addr_of(`PIC_IDX_MASK2)) begin
        core_next.prdata = {24'h00_0000, core_reg.mask2};
      end else if (adr == addr_of(`PIC_IDX_MASK3)) begin
        core_next.prdata = {24'h00_0000, core_reg.mask3};
      end else begin
        core_next.pslverr = 1'b1;
      end
    end

    // Writes land in the access cycle, zero wait states
    wen = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_i.pstrb[0] & ~core_reg.pslverr;
    if (wen) begin
      if (adr == addr_of(`PIC_IDX_CLEAR0)) begin
        own = slots_of(8'hff, 8'h00, 8'h00);
        data = slots_of(wd, 8'h00, 8'h00);
      end else if (adr == addr_of(`PIC_IDX_CLEAR1)) begin
        own = slots_of(8'h00, 8'hff, 8'h00);
        data = slots_of(8'h00, wd, 8'h00);
      end else if (adr == addr_of(`PIC_IDX_CLEAR2)) begin
        own = slots_of(8'h00, 8'h00, 8'hff);
        data = slots_of(8'h00, 8'h00, wd);
      end else if (adr == addr_of(`PIC_IDX_MASK0)) begin
        core_next.mask0 = wd & `PIC_M0_WMASK;
      end else if (adr == addr_of(`PIC_IDX_MASK1)) begin
        core_next.mask1 = wd & `PIC_M1_WMASK;
      end else if (adr == addr_of(`PIC_IDX_MASK2)) begin
        core_next.mask2 = wd & `PIC_M2_WMASK;
      end else if (adr == addr_of(`PIC_IDX_MASK3)) begin
        core_next.mask3 = wd & `PIC_M3_WMASK;
      end
      sw_clear = own & ~data;
      if (core_reg.mask3[`PIC_M3_SW_ENABLE]) begin
        sw_set = data;
      end
    end

    case (core_reg.st)
      pic_pkg::PIC_IDLE: begin
        // Start only at an instruction boundary with global enable
        if (instr_done_i && global_interrupt_enable_i
            && (pending != '0)) begin
          pick = first_slot(pending);
          core_next.st = pic_pkg::PIC_DISPATCH;
          core_next.cnt = 4'd0;
          core_next.slot = pick;
          core_next.ctx = ctx_i;
          core_next.disp.busy = 1'b1;
          core_next.disp.vector = vector_of(pick);
          take_clear = 26'h1 << pick;
        end
      end
      pic_pkg::PIC_DISPATCH: begin
        core_next.cnt = core_reg.cnt + 4'd1;
        if (core_reg.cnt == `PIC_STEP_PUSH_PC_HIGH) begin
          core_next.disp.push = 1'b1;
          core_next.disp.push_data = core_reg.ctx.pc[15:8];
        end else if (core_reg.cnt == `PIC_STEP_PUSH_PC_LOW) begin
          core_next.disp.push = 1'b1;
          core_next.disp.push_data = core_reg.ctx.pc[7:0];
        end else if (core_reg.cnt == `PIC_STEP_PUSH_FLAGS) begin
          core_next.disp.push = 1'b1;
          core_next.disp.push_data = core_reg.ctx.flags;
        end else if (core_reg.cnt == `PIC_STEP_CLEAR_FLAGS) begin
          core_next.disp.flags_clear = 1'b1;
        end else if (core_reg.cnt == `PIC_STEP_LOAD_PC) begin
          core_next.disp.pc_load = 1'b1;
          core_next.disp.pc_value = {8'h00, core_reg.disp.vector};
          core_next.disp.busy = 1'b0;
          core_next.st = pic_pkg::PIC_IDLE;
        end
      end
      default: begin
        core_next.st = pic_pkg::PIC_IDLE;
        core_next.disp.busy = 1'b0;
      end
    endcase

    // Hardware set wins over any clear in the same cycle
    core_next.posted = ((core_reg.posted & ~sw_clear & ~take_clear) | sw_set | hw_set)
      & `PIC_VALID_SLOTS;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign apb_o.pready = 1'b1;
  assign apb_o.prdata = core_reg.prdata;
  assign apb_o.pslverr = core_reg.pslverr;
  assign disp_o = core_reg.disp;
  assign irq_request_o = global_interrupt_enable_i & (pending != '0)
    & (core_reg.st == pic_pkg::PIC_IDLE);
endmodule // pic_controller

// ### hw/pic_regs.svh
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

`define PIC_ADDR_W 12
`define PIC_IDX_CLEAR0 8'hda
`define PIC_IDX_CLEAR1 8'hdb
`define PIC_IDX_CLEAR2 8'hdc
`define PIC_IDX_MASK3 8'hde
`define PIC_IDX_MASK2 8'hdf
`define PIC_IDX_MASK0 8'he0
`define PIC_IDX_MASK1 8'he1
`define PIC_RESET_BYTE 8'h00

`define PIC_SLOTS 26
`define PIC_SLOT_W 5
`define PIC_VALID_SLOTS 26'h2167ffe
`define PIC_SLOT_POWER_ON 1
`define PIC_SLOT_EXT0 2
`define PIC_SLOT_SPI_TX 3
`define PIC_SLOT_SPI_RX 4
`define PIC_SLOT_GPIO0 5
`define PIC_SLOT_GPIO1 6
`define PIC_SLOT_EXT1 7
`define PIC_SLOT_USB_FIRST 8
`define PIC_SLOT_WRAP 17
`define PIC_SLOT_EXT2 18
`define PIC_SLOT_GPIO2 20
`define PIC_SLOT_SLEEP 25

`define PIC_C0_POWER_ON 0
`define PIC_C0_EXT0 1
`define PIC_C0_SPI_TX 2
`define PIC_C0_SPI_RX 3
`define PIC_C0_GPIO0 4
`define PIC_C0_EXT1 5
`define PIC_C0_SLEEP 6
`define PIC_C0_GPIO1 7
`define PIC_C1_FIELDS 7
`define PIC_C2_WRAP 1
`define PIC_C2_EXT2 2
`define PIC_C2_GPIO2 4
`define PIC_M3_SW_ENABLE 7

`define PIC_M0_WMASK 8'hff
`define PIC_M1_WMASK 8'h7f
`define PIC_M2_WMASK 8'h16
`define PIC_M3_WMASK 8'h80

`define PIC_PIN_COUNT 6
`define PIC_PIN_EXT0 0
`define PIC_PIN_EXT1 1
`define PIC_PIN_EXT2 2
`define PIC_PIN_GPIO0 3
`define PIC_PIN_GPIO1 4
`define PIC_PIN_GPIO2 5

`define PIC_DISPATCH_CYCLES 4'd13
`define PIC_STEP_PUSH_PC_HIGH 4'd1
`define PIC_STEP_PUSH_PC_LOW 4'd2
`define PIC_STEP_PUSH_FLAGS 4'd3
`define PIC_STEP_CLEAR_FLAGS 4'd4
`define PIC_STEP_LOAD_PC 4'd12
`define PIC_LONG_JUMP_CYCLES 7
`endif

// ### hw/pic_pkg.sv
`include "pic_regs.svh"
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_DISPATCH = 2'b01
  } pic_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PIC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pic_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pic_apb_rsp_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] flags;
  } pic_cpu_ctx_t;

  typedef struct packed {
    logic busy;
    logic push;
    logic [7:0] push_data;
    logic flags_clear;
    logic pc_load;
    logic [15:0] pc_value;
    logic [7:0] vector;
  } pic_dispatch_t;

  typedef struct packed {
    logic [`PIC_PIN_COUNT-1:0] meta;
    logic [`PIC_PIN_COUNT-1:0] sync;
    logic [`PIC_PIN_COUNT-1:0] prev;
    logic [`PIC_PIN_COUNT-1:0] rise;
  } pic_sync_t;

  typedef struct packed {
    pic_state_t st;
    logic [3:0] cnt;
    logic [`PIC_SLOT_W-1:0] slot;
    pic_cpu_ctx_t ctx;
    logic [`PIC_SLOTS-1:0] posted;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [31:0] prdata;
    logic pslverr;
    pic_dispatch_t disp;
  } pic_core_t;
endpackage

// ### hw/pic_edge_sync.sv
`timescale 1ns/1ns
`include "pic_regs.svh"
module pic_edge_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [`PIC_PIN_COUNT-1:0] level_i,
  output logic [`PIC_PIN_COUNT-1:0] rise_o
);
  pic_pkg::pic_sync_t sync_reg;
  pic_pkg::pic_sync_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = level_i;
    sync_next.sync = sync_reg.meta;
    sync_next.prev = sync_reg.sync;
    // Rising edge only, one cycle per edge
    sync_next.rise = sync_reg.sync & ~sync_reg.prev;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign rise_o = sync_reg.rise;
endmodule // pic_edge_sync

// ### dv/pic_asserts.sv
`timescale 1ns/1ns
`include "pic_regs.svh"
module pic_asserts (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire pic_pkg::pic_apb_req_t apb_i,
  input wire pic_pkg::pic_apb_rsp_t apb_o,
  input wire logic [`PIC_SLOTS-1:0] event_i,
  input wire logic [2:0] ext_int_i,
  input wire logic [2:0] gpio_port_i,
  input wire logic global_interrupt_enable_i,
  input wire logic instr_done_i,
  input wire pic_pkg::pic_cpu_ctx_t ctx_i,
  input wire pic_pkg::pic_dispatch_t disp_o,
  input wire logic irq_request_o
);
  localparam logic [25:0] VALID = `PIC_VALID_SLOTS;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_take_gated: assert property ($rose(disp_o.busy) |->
    $past(global_interrupt_enable_i) && $past(instr_done_i))
    else $error("dispatch began without enable at a boundary");
  a_busy_length: assert property ($rose(disp_o.busy) |->
    disp_o.busy[*8] ##5 disp_o.busy ##1 !disp_o.busy) else $error("busy length wrong");
  a_push_order: assert property ($rose(disp_o.busy) |->
    ##2 (disp_o.push && disp_o.push_data == $past(ctx_i.pc[15:8], 3))
    ##1 (disp_o.push && disp_o.push_data == $past(ctx_i.pc[7:0], 4))
    ##1 (disp_o.push && disp_o.push_data == $past(ctx_i.flags, 5)))
    else $error("stack pushes out of order");
  a_flags_cleared: assert property ($rose(disp_o.busy) |-> ##5 disp_o.flags_clear)
    else $error("flag clear missing");
  a_pc_load: assert property ($rose(disp_o.busy) |-> ##13 disp_o.pc_load
    && disp_o.pc_value == {8'h00, disp_o.vector}) else $error("program counter load wrong");
  a_vector_legal: assert property (disp_o.pc_load |-> disp_o.vector < 8'h68
    && disp_o.vector[1:0] == 2'b00 && VALID[disp_o.vector[6:2]]) else $error("bad vector");
  a_irq_gated: assert property (irq_request_o |->
    global_interrupt_enable_i && !disp_o.busy) else $error("request without enable");
  a_clear0_mapped: assert property (apb_i.psel && !apb_i.penable
    && apb_i.paddr == 12'h368 |=> !apb_o.pslverr) else $error("clear register refused");
  cover property ($rose(disp_o.busy));
  cover property (disp_o.pc_load && disp_o.vector == 8'h64);
  cover property (apb_i.psel && apb_i.penable && apb_o.pslverr);
endmodule // pic_asserts
bind pic_controller pic_asserts pic_asserts_i (.clock_i, .rst_n_i, .apb_i, .apb_o, .event_i,
  .ext_int_i, .gpio_port_i, .global_interrupt_enable_i, .instr_done_i, .ctx_i, .disp_o,
  .irq_request_o);

// ### dv/pic_cpu_model.sv
`timescale 1ns/1ns
module pic_cpu_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire pic_pkg::pic_dispatch_t disp_i,
  input wire logic en_set_i,
  input wire logic ret_i,
  output logic glob_en_o,
  output logic instr_done_o,
  output pic_pkg::pic_cpu_ctx_t ctx_o
);
  logic [7:0] stk [0:7];
  logic [2:0] sp;
  logic [2:0] cnt;
  logic [15:0] pc_q;
  assign ctx_o = {pc_q, glob_en_o, 7'h2a};
  assign instr_done_o = cnt == 3'd0 && !disp_i.busy;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q <= 16'hab12;
      glob_en_o <= 1'b0;
      sp <= 3'd0;
      cnt <= 3'd2;
    end else begin
      cnt <= (cnt != 3'd0) ? cnt - 3'd1 : (disp_i.busy ? 3'd0 : 3'd2);
      if (disp_i.push) begin
        stk[sp] <= disp_i.push_data;
        sp <= sp + 3'd1;
      end
      if (disp_i.flags_clear) glob_en_o <= 1'b0;
      if (en_set_i) glob_en_o <= 1'b1;
      if (disp_i.pc_load) begin
        pc_q <= disp_i.pc_value;
        cnt <= 3'd6;
      end
      if (ret_i) begin
        pc_q <= {stk[sp-3'd3], stk[sp-3'd2]};
        glob_en_o <= stk[sp-3'd1][7];
        sp <= sp - 3'd3;
      end
    end
  end
endmodule // pic_cpu_model

// ### dv/pic_controller_tb.sv
`timescale 1ns/1ns
`include "pic_regs.svh"
module pic_controller_tb;
  localparam logic [25:0] VALID = `PIC_VALID_SLOTS;
  logic clock_i = 0;
  logic rst_n_i = 0;
  pic_pkg::pic_apb_req_t apb = '0;
  pic_pkg::pic_apb_rsp_t rsp;
  logic [25:0] ev = '0;
  logic [2:0] ext = '0;
  logic [2:0] gpio = '0;
  logic en_set = 0;
  logic ret = 0;
  logic glob_en, done, irq, err;
  pic_pkg::pic_cpu_ctx_t ctx;
  pic_pkg::pic_dispatch_t disp;
  logic [31:0] rd;
  logic [7:0] v;
  int n_fail = 0;
  int n_compared = 0;
  initial forever #4 clock_i = ~clock_i;
  pic_controller pic_controller_i (.clock_i, .rst_n_i, .apb_i(apb), .apb_o(rsp), .event_i(ev),
    .ext_int_i(ext), .gpio_port_i(gpio), .global_interrupt_enable_i(glob_en),
    .instr_done_i(done), .ctx_i(ctx), .disp_o(disp), .irq_request_o(irq));
  pic_cpu_model pic_cpu_model_i (.clock_i, .rst_n_i, .disp_i(disp), .en_set_i(en_set),
    .ret_i(ret), .glob_en_o(glob_en), .instr_done_o(done), .ctx_o(ctx));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout();
    n_fail++;
    summarize();
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge clock_i);
    apb <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h0, d}, 4'hf};
    @(posedge clock_i);
    apb.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 20) timeout();
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
  endtask
  task automatic take();
    int i;
    for (i = 0; i < 99; i++) begin
      @(posedge clock_i);
      if (disp.pc_load === 1'b1) break;
    end
    if (i == 99) timeout();
    v = disp.vector;
  endtask
  task automatic strobe(input logic g, input logic r, input logic [25:0] m);
    @(posedge clock_i);
    en_set <= g;
    ret <= r;
    ev <= m;
    @(posedge clock_i);
    en_set <= 1'b0;
    ret <= 1'b0;
    ev <= '0;
  endtask
  task automatic t_regs();
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h0);
    bus(0, 8'h10, 8'h00);
    check({31'h0, err}, 32'h1);
    bus(1, `PIC_IDX_MASK3, 8'hff);
    bus(0, `PIC_IDX_MASK3, 8'h00);
    check(rd, 32'h80);
    bus(1, `PIC_IDX_MASK3, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_post();
    strobe(1, 0, '0);
    gpio[1] <= 1'b1;
    repeat (8) @(posedge clock_i);
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h80);
    check({31'h0, irq}, 32'h0);
    bus(1, `PIC_IDX_CLEAR0, 8'h00);
    repeat (6) @(posedge clock_i);
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h0);
    gpio[1] <= 1'b0;
    repeat (6) @(posedge clock_i);
    gpio[1] <= 1'b1;
    repeat (8) @(posedge clock_i);
    bus(1, `PIC_IDX_MASK0, 8'h80);
    take();
    check({24'h0, v}, 32'h18);
    gpio[1] <= 1'b0;
    strobe(0, 1, '0);
    $display("t_post done");
  endtask
  task automatic t_sw();
    bus(1, `PIC_IDX_MASK0, 8'h00);
    bus(1, `PIC_IDX_CLEAR0, 8'hff);
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h0);
    bus(1, `PIC_IDX_MASK3, 8'h80);
    bus(1, `PIC_IDX_CLEAR0, 8'h7e);
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h7e);
    bus(1, `PIC_IDX_CLEAR0, 8'h5a);
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h5a);
    bus(1, `PIC_IDX_CLEAR0, 8'h00);
    bus(1, `PIC_IDX_MASK3, 8'h00);
    $display("t_sw done");
  endtask
  task automatic t_pins();
    ext <= 3'b101;
    gpio[2] <= 1'b1;
    repeat (8) @(posedge clock_i);
    bus(0, `PIC_IDX_CLEAR2, 8'h00);
    check(rd, 32'h14);
    bus(0, `PIC_IDX_CLEAR0, 8'h00);
    check(rd, 32'h02);
    bus(1, `PIC_IDX_CLEAR2, 8'h00);
    bus(1, `PIC_IDX_CLEAR0, 8'h00);
    ext <= 3'b000;
    gpio[2] <= 1'b0;
    repeat (6) @(posedge clock_i);
    bus(0, `PIC_IDX_CLEAR2, 8'h00);
    check(rd, 32'h0);
    $display("t_pins done");
  endtask
  task automatic t_prio();
    bus(1, `PIC_IDX_MASK0, 8'hff);
    bus(1, `PIC_IDX_MASK1, 8'h7f);
    bus(1, `PIC_IDX_MASK2, 8'h16);
    for (int s = 0; s < 26; s++) begin
      strobe(0, 0, 26'd1 << s);
      if (VALID[s]) begin
        take();
        check({24'h0, v}, 32'(s * 4));
        check({8'h0, pic_cpu_model_i.stk[0], pic_cpu_model_i.stk[1],
          pic_cpu_model_i.stk[2]}, 32'hab12aa);
        check({31'h0, glob_en}, 32'h0);
        strobe(0, 1, '0);
      end else begin
        repeat (6) @(posedge clock_i);
        check({31'h0, irq}, 32'h0);
      end
    end
    $display("t_prio done");
  endtask
  task automatic t_nest();
    strobe(0, 0, 26'h2000008);
    take();
    check({24'h0, v}, 32'h0c);
    strobe(1, 0, '0);
    take();
    check({24'h0, v}, 32'h64);
    strobe(0, 1, '0);
    strobe(0, 1, 26'h0002010);
    take();
    check({24'h0, v}, 32'h10);
    strobe(0, 1, '0);
    take();
    check({24'h0, v}, 32'h34);
    strobe(0, 1, '0);
    $display("t_nest done");
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_post();
    t_sw();
    t_pins();
    t_prio();
    t_nest();
    summarize();
  end
endmodule // pic_controller_tb
